// ---- common/sfsi_pkg.sv ----
// types shared by the sensor fifo block and its bench
package sfsi_pkg;

    // ============================================================
    // frame type selection
    typedef enum logic [1:0] {
        SFSI_FR_OFF = 2'b00,
        SFSI_FR_T   = 2'b01,
        SFSI_FR_P   = 2'b10,
        SFSI_FR_PT  = 2'b11
    } sfsi_frame_t;

    // ============================================================
    // bus and measurement carriers
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } sfsi_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } sfsi_apb_rsp_t;

    typedef struct packed {
        logic [23:0] temp;
        logic [23:0] press;
    } sfsi_meas_t;

    // ============================================================
    // complete state of the block
    typedef struct packed {
        sfsi_frame_t      frame;
        logic             stop;
        logic [2:0]       dec;
        logic [1:0]       pwr;
        logic [11:0]      sens;
        logic [4:0]       thresh;
        logic [16:0]      oor_ref;
        logic [7:0]       oor_range;
        logic [3:0]       oor_lim;
        logic [3:0]       oor_cnt;
        logic [31:0][23:0] mem;
        logic [4:0]       rd_ptr;
        logic [4:0]       wr_ptr;
        logic [5:0]       words;
        logic [2:0]       byte_idx;
        logic [6:0]       dec_cnt;
        sfsi_meas_t       vis;
        sfsi_meas_t       shadow;
        logic             sh_pend;
        logic             burst_open;
        logic             data_touched;
        logic [4:0]       status;
        logic [31:0]      prdata;
        logic             slverr;
    } sfsi_state_t;

endpackage

// ---- common/sfsi_regs.svh ----
// register offsets, field positions and reset values of the sensor fifo block
`ifndef SFSI_REGS_SVH
`define SFSI_REGS_SVH

// ============================================================
// register byte offsets
`define SFSI_OFF_CTRL      8'h00
`define SFSI_OFF_SENS      8'h04
`define SFSI_OFF_THRESH    8'h08
`define SFSI_OFF_COUNT     8'h0C
`define SFSI_OFF_DATA      8'h10
`define SFSI_OFF_BURST     8'h14
`define SFSI_OFF_STATUS    8'h18
`define SFSI_OFF_TEMP      8'h1C
`define SFSI_OFF_PRESS     8'h20
`define SFSI_OFF_OOR_REF   8'h24
`define SFSI_OFF_OOR_CFG   8'h28

// ============================================================
// field positions
`define SFSI_CTRL_FRAME    0
`define SFSI_CTRL_STOP     2
`define SFSI_CTRL_DEC      3
`define SFSI_CTRL_PWR      6
`define SFSI_SENS_PEN      11
`define SFSI_OORC_LIM      8
`define SFSI_ST_DRDY       0
`define SFSI_ST_FULL       1
`define SFSI_ST_THS        2
`define SFSI_ST_OOR        3
`define SFSI_ST_POR        4

// ============================================================
// values and reset values
`define SFSI_RST_POR       1'b1
`define SFSI_PWR_STANDBY   2'b00
`define SFSI_EMPTY_BYTE    8'h7F
`define SFSI_FIFO_WORDS    6'd32
`define SFSI_MAX_PT        6'd16
`define SFSI_MAX_SINGLE    6'd32

`endif

// ---- design/sfsi_core.sv ----
// sensor data path: result shadowing, frame fifo and status flags
`timescale 1ns/100ps
`default_nettype none
`include "sfsi_regs.svh"

module sfsi_core (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire sfsi_pkg::sfsi_apb_req_t apb_req,
    output var  sfsi_pkg::sfsi_apb_rsp_t apb_rsp,
    input  wire logic                   meas_valid,
    input  wire sfsi_pkg::sfsi_meas_t   meas_data,
    output logic                        press_needed
);
    import sfsi_pkg::*;

    sfsi_state_t s_reg;
    sfsi_state_t s_next;

    // ============================================================
    // helpers
    function automatic logic [5:0] frames_of(input logic [5:0] w, input sfsi_frame_t f);
        frames_of = (f == SFSI_FR_PT) ? {1'b0, w[5:1]} : w;
    endfunction

    // full when occupancy reaches the frame type maximum
    function automatic logic full_cond(input logic [5:0] w, input sfsi_frame_t f);
        logic [5:0] fr;
        fr = frames_of(w, f);
        full_cond = (f != SFSI_FR_OFF) &&
                    (fr == ((f == SFSI_FR_PT) ? `SFSI_MAX_PT : `SFSI_MAX_SINGLE));
    endfunction

    // threshold level, top bit dropped for dual frames
    function automatic logic ths_cond(input logic [5:0] w, input sfsi_frame_t f,
                                      input logic [4:0] t);
        logic [4:0] lvl;
        lvl = (f == SFSI_FR_PT) ? {1'b0, t[3:0]} : t;
        ths_cond = (f != SFSI_FR_OFF) && (lvl != 5'h00) &&
                   (frames_of(w, f) >= {1'b0, lvl});
    endfunction

    // ============================================================
    // decoded bus and fifo views
    logic       acc;
    logic       setup;
    logic       wr_acc;
    logic       rd_acc;
    logic       burst_end;
    logic       reading;
    logic       fifo_en;
    logic [5:0] fw;
    logic       mapped;

    assign acc     = apb_req.psel && apb_req.penable;
    assign setup   = apb_req.psel && !apb_req.penable;
    assign wr_acc  = acc && apb_req.pwrite;
    assign rd_acc  = acc && !apb_req.pwrite;
    assign fifo_en = (s_reg.frame != SFSI_FR_OFF);
    assign fw      = (s_reg.frame == SFSI_FR_PT) ? 6'd2 : 6'd1;
    assign mapped  = (apb_req.paddr <= `SFSI_OFF_OOR_CFG) && (apb_req.paddr[1:0] == 2'b00);
    // a burst ends on closing write, or after any lone access outside one
    assign burst_end = acc && ((apb_req.pwrite && apb_req.paddr == `SFSI_OFF_BURST &&
                                !apb_req.pwdata[0]) ||
                               (!s_reg.burst_open &&
                                !(apb_req.pwrite && apb_req.paddr == `SFSI_OFF_BURST)));
    // host is inside a burst over the result registers
    assign reading = s_reg.burst_open && s_reg.data_touched && !burst_end;

    // pressure conversion forced by pressure frames
    assign press_needed = s_reg.sens[`SFSI_SENS_PEN] || s_reg.frame[1];

    // bus answer, pready in access phase, data from flops
    assign apb_rsp = '{pready:  apb_req.psel && apb_req.penable,
                       pslverr: s_reg.slverr,
                       prdata:  s_reg.prdata};

    // ============================================================
    // next state
    always_comb begin
        logic [4:0]  idx;
        logic [23:0] word;
        logic [7:0]  byte_v;
        logic [2:0]  bsel;
        logic        flush;
        logic [6:0]  dmask;
        logic [7:0]  dpow;
        logic [17:0] p_pa;
        logic [18:0] hi;
        logic        outside;
        logic [3:0]  lim;
        idx     = 5'h00;
        word    = 24'h000000;
        byte_v  = 8'h00;
        bsel    = 3'h0;
        flush   = 1'b0;
        dmask   = 7'h00;
        dpow    = 8'h00;
        p_pa    = 18'h00000;
        hi      = 19'h00000;
        outside = 1'b0;
        lim     = 4'h0;
        s_next  = s_reg;

        // fifo byte under the read cursor, low byte first
        idx  = s_reg.rd_ptr + ((s_reg.byte_idx >= 3'd3) ? 5'd1 : 5'd0);
        bsel = (s_reg.byte_idx >= 3'd3) ? (s_reg.byte_idx - 3'd3) : s_reg.byte_idx;
        word = s_reg.mem[idx];
        unique case (bsel)
            3'd0:    byte_v = word[7:0];
            3'd1:    byte_v = word[15:8];
            default: byte_v = word[23:16];
        endcase
        if (!fifo_en || s_reg.words < fw) begin
            byte_v = `SFSI_EMPTY_BYTE;
        end

        // read data latched in setup phase
        if (setup) begin
            s_next.slverr = !mapped;
            s_next.prdata = 32'h00000000;
            unique case (apb_req.paddr)
                `SFSI_OFF_CTRL:    s_next.prdata = {24'h000000, s_reg.pwr, s_reg.dec,
                                                    s_reg.stop, s_reg.frame};
                `SFSI_OFF_SENS:    s_next.prdata = {20'h00000, s_reg.sens};
                `SFSI_OFF_THRESH:  s_next.prdata = {27'h0000000, s_reg.thresh};
                `SFSI_OFF_COUNT:   s_next.prdata = {26'h0000000,
                                                    frames_of(s_reg.words, s_reg.frame)};
                `SFSI_OFF_DATA:    s_next.prdata = {24'h000000, byte_v};
                `SFSI_OFF_BURST:   s_next.prdata = {31'h00000000, s_reg.burst_open};
                `SFSI_OFF_STATUS:  s_next.prdata = {27'h0000000, s_reg.status};
                `SFSI_OFF_TEMP:    s_next.prdata = {8'h00, s_reg.vis.temp};
                `SFSI_OFF_PRESS:   s_next.prdata = {8'h00, s_reg.vis.press};
                `SFSI_OFF_OOR_REF: s_next.prdata = {15'h0000, s_reg.oor_ref};
                `SFSI_OFF_OOR_CFG: s_next.prdata = {20'h00000, s_reg.oor_lim, s_reg.oor_range};
                default:           s_next.prdata = 32'h00000000;
            endcase
        end

        // read side effects at the access edge
        if (rd_acc) begin
            if (apb_req.paddr == `SFSI_OFF_TEMP || apb_req.paddr == `SFSI_OFF_PRESS) begin
                s_next.data_touched = s_reg.burst_open;
            end
            if (apb_req.paddr == `SFSI_OFF_DATA && fifo_en && s_reg.words >= fw) begin
                if ({3'b000, s_reg.byte_idx} + 6'd1 == 6'd3 * fw) begin
                    s_next.rd_ptr   = s_reg.rd_ptr + fw[4:0];
                    s_next.words    = s_reg.words - fw;
                    s_next.byte_idx = 3'h0;
                end else begin
                    s_next.byte_idx = s_reg.byte_idx + 3'd1;
                end
            end
            if (apb_req.paddr == `SFSI_OFF_STATUS) begin
                s_next.status[`SFSI_ST_DRDY] = 1'b0;
                s_next.status[`SFSI_ST_OOR]  = 1'b0;
                s_next.status[`SFSI_ST_POR]  = 1'b0;
            end
        end

        // register writes
        if (wr_acc) begin
            unique case (apb_req.paddr)
                `SFSI_OFF_CTRL: begin
                    s_next.stop = apb_req.pwdata[`SFSI_CTRL_STOP];
                    s_next.pwr  = apb_req.pwdata[`SFSI_CTRL_PWR +: 2];
                    if (s_reg.pwr == `SFSI_PWR_STANDBY) begin
                        s_next.frame = sfsi_frame_t'(apb_req.pwdata[`SFSI_CTRL_FRAME +: 2]);
                        s_next.dec   = apb_req.pwdata[`SFSI_CTRL_DEC +: 3];
                    end
                    flush = (s_next.pwr != s_reg.pwr) || (s_next.frame != s_reg.frame) ||
                            (s_next.dec != s_reg.dec);
                end
                `SFSI_OFF_SENS: begin
                    s_next.sens = apb_req.pwdata[11:0];
                    flush = (apb_req.pwdata[10:0] != s_reg.sens[10:0]);
                end
                `SFSI_OFF_THRESH:  s_next.thresh = apb_req.pwdata[4:0];
                `SFSI_OFF_BURST:   s_next.burst_open = apb_req.pwdata[0];
                `SFSI_OFF_OOR_REF: s_next.oor_ref = apb_req.pwdata[16:0];
                `SFSI_OFF_OOR_CFG: begin
                    s_next.oor_range = apb_req.pwdata[7:0];
                    s_next.oor_lim   = apb_req.pwdata[`SFSI_OORC_LIM +: 4];
                end
                default: s_next.oor_lim = s_next.oor_lim;
            endcase
        end

        // burst end: publish shadow, resend partial frame, drop stale fifo flags
        if (burst_end) begin
            s_next.burst_open   = 1'b0;
            s_next.data_touched = 1'b0;
            s_next.byte_idx     = 3'h0;
            if (s_reg.sh_pend) begin
                s_next.vis                   = s_reg.shadow;
                s_next.sh_pend               = 1'b0;
                s_next.status[`SFSI_ST_DRDY] = 1'b1;
            end
            if (!full_cond(s_next.words, s_next.frame)) begin
                s_next.status[`SFSI_ST_FULL] = 1'b0;
            end
            if (!ths_cond(s_next.words, s_next.frame, s_next.thresh)) begin
                s_next.status[`SFSI_ST_THS] = 1'b0;
            end
        end

        // flush on reconfiguration
        if (flush) begin
            s_next.rd_ptr                = 5'h00;
            s_next.wr_ptr                = 5'h00;
            s_next.words                 = 6'h00;
            s_next.byte_idx              = 3'h0;
            s_next.dec_cnt               = 7'h00;
            s_next.oor_cnt               = 4'h0;
            s_next.status[`SFSI_ST_FULL] = 1'b0;
            s_next.status[`SFSI_ST_THS]  = 1'b0;
            s_next.status[`SFSI_ST_OOR]  = 1'b0;
        end

        // measurement completion
        if (meas_valid) begin
            if (reading) begin
                s_next.shadow  = meas_data;
                s_next.sh_pend = 1'b1;
            end else begin
                s_next.vis                   = meas_data;
                s_next.status[`SFSI_ST_DRDY] = 1'b1;
            end
            // decimation: only a zero count stores a frame
            dpow           = 8'h01 << s_next.dec;
            dmask          = 7'(dpow - 8'h01);
            // count is advanced first, so a stored slot shows as the count just past zero
            s_next.dec_cnt = flush ? 7'h00 : ((s_next.dec_cnt + 7'd1) & dmask);
            if (s_next.frame != SFSI_FR_OFF && s_next.dec_cnt == (7'h01 & dmask)
                && !flush) begin
                if (s_next.words + fw > `SFSI_FIFO_WORDS && !s_next.stop) begin
                    s_next.rd_ptr   = s_next.rd_ptr + fw[4:0];
                    s_next.words    = s_next.words - fw;
                    s_next.byte_idx = 3'h0;
                end
                if (s_next.words + fw <= `SFSI_FIFO_WORDS) begin
                    unique case (s_next.frame)
                        SFSI_FR_PT: begin
                            s_next.mem[s_next.wr_ptr]        = meas_data.temp;
                            s_next.mem[s_next.wr_ptr + 5'd1] = meas_data.press;
                        end
                        SFSI_FR_T: s_next.mem[s_next.wr_ptr] = meas_data.temp;
                        default:   s_next.mem[s_next.wr_ptr] = meas_data.press;
                    endcase
                    s_next.wr_ptr = s_next.wr_ptr + fw[4:0];
                    s_next.words  = s_next.words + fw;
                end
            end
            // fifo flags raised at measurement end
            if (full_cond(s_next.words, s_next.frame)) begin
                s_next.status[`SFSI_ST_FULL] = 1'b1;
            end
            if (ths_cond(s_next.words, s_next.frame, s_next.thresh)) begin
                s_next.status[`SFSI_ST_THS] = 1'b1;
            end
            // pressure window in pascals
            p_pa    = meas_data.press[23:6];
            hi      = {2'b00, s_reg.oor_ref} + {11'h000, s_reg.oor_range};
            outside = ({1'b0, p_pa} > hi) ||
                      (({1'b0, p_pa} + {11'h000, s_reg.oor_range}) < {2'b00, s_reg.oor_ref});
            lim     = (s_reg.oor_lim == 4'h0) ? 4'h1 : s_reg.oor_lim;
            if (outside && !flush) begin
                if (s_reg.oor_cnt != 4'hF) begin
                    s_next.oor_cnt = s_reg.oor_cnt + 4'd1;
                end
                if (s_reg.oor_cnt + 4'd1 >= lim || s_reg.oor_cnt == 4'hF) begin
                    s_next.status[`SFSI_ST_OOR] = 1'b1;
                end
            end else begin
                s_next.oor_cnt = 4'h0;
            end
        end

        // threshold write re-evaluates the flag against the new level
        if (wr_acc && apb_req.paddr == `SFSI_OFF_THRESH) begin
            s_next.status[`SFSI_ST_THS] = ths_cond(s_next.words, s_next.frame,
                                                   s_next.thresh);
        end
    end

    // ============================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg                     <= '0;
            s_reg.frame               <= SFSI_FR_OFF;
            s_reg.status[`SFSI_ST_POR] <= `SFSI_RST_POR;
        end else begin
            s_reg <= s_next;
        end
    end

    // ============================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // no bus traffic, so a measurement edge is the only cause of fifo motion
    logic quiet;
    assign quiet = !apb_req.psel;

    a_fifo_cap: assert property (s_reg.words <= `SFSI_FIFO_WORDS)
        else $error("fifo holds more words than storage");
    a_empty_byte: assert property (setup && apb_req.paddr == `SFSI_OFF_DATA && !fifo_en
        |=> s_reg.prdata == 32'h0000007F)
        else $error("disabled fifo did not return empty byte");
    a_flush_zero: assert property (wr_acc && apb_req.paddr == `SFSI_OFF_SENS
        && apb_req.pwdata[10:0] != s_reg.sens[10:0]
        |=> s_reg.words == 6'h00 && !s_reg.status[`SFSI_ST_FULL])
        else $error("flush left fifo content");
    a_stop_keep: assert property (quiet && meas_valid && s_reg.stop && fifo_en
        && s_reg.words == `SFSI_FIFO_WORDS
        |=> $stable(s_reg.rd_ptr) && s_reg.words == `SFSI_FIFO_WORDS)
        else $error("stop on full discarded a frame");
    a_stream_drop: assert property (quiet && meas_valid && !s_reg.stop && fifo_en
        && s_reg.dec == 3'h0 && s_reg.words == `SFSI_FIFO_WORDS
        |=> s_reg.rd_ptr == $past(s_reg.rd_ptr) + $past(fw[4:0]))
        else $error("streaming did not drop oldest frame");
    a_shadow_hold: assert property (meas_valid && reading
        |=> $stable(s_reg.vis) && s_reg.sh_pend)
        else $error("visible results overwritten during burst");
    a_drdy_set: assert property (meas_valid && !reading
        |=> s_reg.status[`SFSI_ST_DRDY])
        else $error("data ready not raised");
    a_por_clear: assert property (rd_acc && apb_req.paddr == `SFSI_OFF_STATUS
        |=> !s_reg.status[`SFSI_ST_POR])
        else $error("status read kept power-up flag");
    a_ths_write: assert property (wr_acc && apb_req.paddr == `SFSI_OFF_THRESH && !meas_valid
        |=> s_reg.status[`SFSI_ST_THS] == ths_cond(s_reg.words, s_reg.frame, s_reg.thresh))
        else $error("threshold flag not re-evaluated");
    a_press_force: assert property ((s_reg.frame == SFSI_FR_P || s_reg.frame == SFSI_FR_PT)
        |-> press_needed)
        else $error("pressure not requested for pressure frames");

endmodule

`default_nettype wire

// ---- testbench/sfsi_core_tb_top.sv ----
// self-checking bench for the sensor fifo block
`timescale 1ns/100ps
`default_nettype none
`include "sfsi_regs.svh"
module sfsi_core_tb_top;
    import sfsi_pkg::*;
    logic          pclk;
    logic          presetn;
    sfsi_apb_req_t req;
    sfsi_apb_rsp_t rsp;
    logic          meas_valid;
    sfsi_meas_t    meas_data;
    logic          press_needed;
    int            bad_count;
    int            tests_run;
    int            cyc;
    int            i;

    sfsi_core dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .meas_valid(meas_valid), .meas_data(meas_data), .press_needed(press_needed));
    sfsi_meas_src src_u (.pclk(pclk), .meas_valid(meas_valid), .meas_data(meas_data));

    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // value compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // apb transfer: setup, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    // n measurements carrying their index in both fields
    task automatic fill(input int n);
        for (int k = 0; k < n; k++) src_u.send(24'(k), 24'(k));
    endtask

    // main sequence
    initial begin
        presetn = 1'b0;
        req = '0;
        bad_count = 0;
        tests_run = 0;
        cyc = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rc(`SFSI_OFF_STATUS, 32'h10);
        rc(`SFSI_OFF_STATUS, 32'h00);
        wr(`SFSI_OFF_CTRL, 32'h3);
        src_u.send(24'h332211, 24'h665544);
        rc(`SFSI_OFF_STATUS, 32'h09);
        rc(`SFSI_OFF_COUNT, 32'h1);
        wr(`SFSI_OFF_BURST, 32'h1);
        for (i = 0; i < 3; i++) rc(`SFSI_OFF_DATA, 8'h11 * (i + 1));
        wr(`SFSI_OFF_BURST, 32'h0);
        wr(`SFSI_OFF_BURST, 32'h1);
        for (i = 0; i < 7; i++) rc(`SFSI_OFF_DATA, i < 6 ? 8'h11 * (i + 1) : 8'h7F);
        wr(`SFSI_OFF_BURST, 32'h0);
        rc(`SFSI_OFF_COUNT, 32'h0);
        wr(`SFSI_OFF_BURST, 32'h1);
        rc(`SFSI_OFF_TEMP, 32'h332211);
        src_u.send(24'h0A0B0C, 24'h0D0E0F);
        rc(`SFSI_OFF_PRESS, 32'h665544);
        wr(`SFSI_OFF_BURST, 32'h0);
        rc(`SFSI_OFF_TEMP, 32'h0A0B0C);
        wr(`SFSI_OFF_THRESH, 32'h1);
        rc(`SFSI_OFF_STATUS, 32'h0D);
        rc(`SFSI_OFF_STATUS, 32'h04);
        wr(`SFSI_OFF_THRESH, 32'h2);
        rc(`SFSI_OFF_STATUS, 32'h00);
        wr(`SFSI_OFF_THRESH, 32'h11);
        rc(`SFSI_OFF_STATUS, 32'h04);
        wr(`SFSI_OFF_CTRL, 32'h1);
        rc(`SFSI_OFF_STATUS, 32'h00);
        rc(`SFSI_OFF_COUNT, 32'h0);
        fill(33);
        rc(`SFSI_OFF_COUNT, 32'd32);
        rc(`SFSI_OFF_STATUS, 32'h07);
        rc(`SFSI_OFF_DATA, 32'h01);
        wr(`SFSI_OFF_BURST, 32'h1);
        for (i = 0; i < 3; i++) rc(`SFSI_OFF_DATA, i == 0 ? 32'h01 : 32'h00);
        wr(`SFSI_OFF_BURST, 32'h0);
        rc(`SFSI_OFF_STATUS, 32'h04);
        chk({31'h0, press_needed}, 32'h0);
        wr(`SFSI_OFF_CTRL, 32'h6);
        @(posedge pclk);
        chk({31'h0, press_needed}, 32'h1);
        fill(33);
        rc(`SFSI_OFF_COUNT, 32'd32);
        rc(`SFSI_OFF_DATA, 32'h00);
        wr(`SFSI_OFF_CTRL, 32'h9);
        fill(3);
        rc(`SFSI_OFF_COUNT, 32'h2);
        wr(`SFSI_OFF_SENS, 32'h801);
        rc(`SFSI_OFF_COUNT, 32'h0);
        chk({31'h0, press_needed}, 32'h1);
        fill(1);
        rc(`SFSI_OFF_COUNT, 32'h1);
        wr(`SFSI_OFF_CTRL, 32'h0);
        rc(`SFSI_OFF_DATA, 32'h7F);
        wr(`SFSI_OFF_CTRL, 32'h40);
        wr(`SFSI_OFF_CTRL, 32'h41);
        rc(`SFSI_OFF_CTRL, 32'h40);
        wr(`SFSI_OFF_OOR_REF, 32'd100);
        wr(`SFSI_OFF_OOR_CFG, 32'h20A);
        for (i = 0; i < 3; i++) begin
            src_u.send(24'h0, 24'(200 << 6));
            rc(`SFSI_OFF_STATUS, i == 0 ? 32'h01 : 32'h09);
        end
        finish_test();
    end
endmodule
`default_nettype wire

// ---- testbench/sfsi_meas_src.sv ----
// measurement source model standing in for the sensor front end
`timescale 1ns/100ps
`default_nettype none
module sfsi_meas_src (
    input  wire logic                 pclk,
    output var  logic                 meas_valid,
    output var  sfsi_pkg::sfsi_meas_t meas_data
);
    import sfsi_pkg::*;
    // quiet at time zero
    initial begin
        meas_valid = 1'b0;
        meas_data  = '0;
    end
    // one-cycle completion pulse; data inverted afterwards so stale values never match
    task automatic send(input logic [23:0] t, input logic [23:0] p);
        @(posedge pclk);
        meas_valid <= 1'b1;
        meas_data  <= '{temp: t, press: p};
        @(posedge pclk);
        meas_valid <= 1'b0;
        meas_data  <= ~{t, p};
        repeat (3) @(posedge pclk);
    endtask
endmodule
`default_nettype wire
